//--- core/dbs_sequencer.sv
// Start-up sequencer: supply gating, configuration latch and check, soft-start
// ramp and power-good outputs for two buck channels.
// Assumes pins and analog comparator results are asynchronous to clk_sys.
`timescale 1ns/1ps

module dbs_sequencer
  import dbs_pkg::*;
#(
  parameter int CHECK_GAP   = CHECK_GAP_CYC,
  parameter int SOFT_START  = SOFT_START_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       ch1_vsel_first,
  input  wire logic       ch1_vsel_second,
  input  wire logic       ch2_vsel_first,
  input  wire logic       ch2_vsel_second,
  input  wire logic       block_cfg_sel_first,
  input  wire logic       block_cfg_sel_second,
  input  wire logic       bias_good_in,
  input  wire logic [5:0] block_supply_in,
  input  wire logic       sys_enable_in,
  input  wire logic       ch1_enable_in,
  input  wire logic       ch2_enable_in,
  input  wire logic [5:0] switch_node_in,
  input  wire logic [1:0] fb_over_115,
  input  wire logic [1:0] fb_below_110,
  input  wire logic [1:0] fb_under_85,
  input  wire logic [1:0] fb_at_90,
  output logic [2:0]      ch1_scale,
  output logic [2:0]      ch2_scale,
  output logic            bias_thresh_high,
  output logic            sys_enable_sink_on,
  output logic [5:0]      switch_node_out,
  output logic [5:0]      switch_node_oe,
  output logic [5:0]      block_pulldown_on,
  output logic            switching_allowed,
  output logic [1:0]      cfg_split,
  output logic            cfg_fault,
  output logic [5:0]      ch1_ref_code,
  output logic [5:0]      ch2_ref_code,
  output logic            ch1_power_good,
  output logic            ch1_power_good_oe,
  output logic            ch2_power_good,
  output logic            ch2_power_good_oe
);

  localparam int NSYNC = 19;

  typedef enum logic [6:0] {
    DBS_IDLE   = 7'h01,
    DBS_PULSE1 = 7'h02,
    DBS_PULSE2 = 7'h04,
    DBS_GAP    = 7'h08,
    DBS_RETRY  = 7'h10,
    DBS_RAMP   = 7'h20,
    DBS_RUN    = 7'h40
  } dbs_state_e;

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;

  assign raw_in = {ch1_vsel_first, ch1_vsel_second, ch2_vsel_first, ch2_vsel_second,
                   block_cfg_sel_first, block_cfg_sel_second, bias_good_in,
                   &block_supply_in, sys_enable_in, ch1_enable_in, ch2_enable_in,
                   switch_node_in, fb_over_115[0], fb_under_85[0]};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  // Feedback comparators for channel one's fast trips go through the vector above;
  // the remaining comparator bits get their own pair of stages here.
  logic [5:0] fb_a;
  logic [5:0] fb_b;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fb_a <= 6'h00;
      fb_b <= 6'h00;
    end else begin
      fb_a <= {fb_over_115[1], fb_under_85[1], fb_below_110, fb_at_90};
      fb_b <= fb_a;
    end
  end

  logic       v1a, v1b, v2a, v2b, cfga, cfgb;
  logic       bias_ok, blocks_ok, sys_en, en1, en2;
  logic [5:0] node_seen;
  assign v1a       = sync_b[18];
  assign v1b       = sync_b[17];
  assign v2a       = sync_b[16];
  assign v2b       = sync_b[15];
  assign cfga      = sync_b[14];
  assign cfgb      = sync_b[13];
  assign bias_ok   = sync_b[12];
  assign blocks_ok = sync_b[11];
  assign sys_en    = sync_b[10];
  assign en1       = sync_b[9];
  assign en2       = sync_b[8];
  assign node_seen = sync_b[7:2];

  // ==========================================================================
  // Voltage selection decode
  // ==========================================================================
  // Open pins are pulled low externally, so 00 is the safe default
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ch1_scale <= DBS_SCALE_EXT;
      ch2_scale <= DBS_SCALE_EXT;
    end else begin
      unique case ({v1a, v1b})
        2'h3:    ch1_scale <= DBS_SCALE_1V8;
        2'h1:    ch1_scale <= DBS_SCALE_1V5;
        2'h2:    ch1_scale <= DBS_SCALE_1V2;
        2'h0:    ch1_scale <= DBS_SCALE_EXT;
      endcase
      unique case ({v2a, v2b})
        2'h3:    ch2_scale <= DBS_SCALE_3V3;
        2'h1:    ch2_scale <= DBS_SCALE_2V5;
        2'h2:    ch2_scale <= DBS_SCALE_1V8;
        2'h0:    ch2_scale <= DBS_SCALE_EXT;
      endcase
    end
  end

  // High threshold only for the 3.3V setting of channel two
  assign bias_thresh_high = (ch2_scale == DBS_SCALE_3V3);

  // Sink stays on until the enable pin crosses its threshold
  assign sys_enable_sink_on = !sys_en;

  // ==========================================================================
  // Block configuration latch
  // ==========================================================================
  logic cfg_held;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_held  <= 1'b0;
      cfg_split <= CFG_RST;
    end else if (!bias_ok) begin
      cfg_held <= 1'b0;
    end else if (!cfg_held) begin
      cfg_held  <= 1'b1;
      cfg_split <= {cfga, cfgb};
    end
  end

  // Expected sharing per split: nodes (bit0=node1) tied to each master
  logic [5:0] exp_ch1;
  logic [5:0] exp_ch2;
  always_comb begin
    unique case (cfg_split)
      2'h3:    begin exp_ch1 = 6'h07; exp_ch2 = 6'h38; end
      2'h2:    begin exp_ch1 = 6'h0f; exp_ch2 = 6'h30; end
      2'h1:    begin exp_ch1 = 6'h2f; exp_ch2 = 6'h10; end
      2'h0:    begin exp_ch1 = 6'h03; exp_ch2 = 6'h3c; end
    endcase
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  dbs_state_e  state;
  logic [22:0] timer;
  logic        checked_ok;
  logic        ch1_ok;
  logic        start_req;
  logic        ramp_done;

  assign start_req = bias_ok && blocks_ok && sys_en && (en1 || en2);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= DBS_IDLE;
      timer      <= '0;
      ch1_ok     <= 1'b0;
      checked_ok <= 1'b0;
      cfg_fault  <= 1'b0;
    end else if (!bias_ok || !blocks_ok || !start_req) begin
      state <= DBS_IDLE;
      timer <= '0;
      if (!bias_ok) begin
        checked_ok <= 1'b0;
      end
    end else begin
      timer <= timer + 23'd1;
      unique case (state)
        DBS_IDLE: begin
          timer <= '0;
          state <= checked_ok ? DBS_RAMP : DBS_PULSE1;
        end
        DBS_PULSE1: if (timer == 23'(PULSE_CYC + SETTLE_CYC)) begin
          ch1_ok <= ((node_seen | DBS_CH1_MASTER) == exp_ch1);
          timer  <= '0;
          state  <= DBS_PULSE2;
        end
        DBS_PULSE2: if (timer == 23'(PULSE_CYC + SETTLE_CYC)) begin
          // Tied masters show up as a mismatch on both passes
          cfg_fault <= !(ch1_ok && ((node_seen | DBS_CH2_MASTER) == exp_ch2));
          timer     <= '0;
          state     <= (ch1_ok && ((node_seen | DBS_CH2_MASTER) == exp_ch2)) ? DBS_GAP : DBS_RETRY;
        end
        DBS_GAP: if (timer == 23'(CHECK_GAP - 1)) begin
          checked_ok <= 1'b1;
          timer      <= '0;
          state      <= DBS_RAMP;
        end
        DBS_RETRY: if (timer == 23'(CHECK_GAP - 1)) begin
          timer <= '0;
          state <= DBS_PULSE1;
        end
        DBS_RAMP: if (ramp_done) begin
          state <= DBS_RUN;
        end
        DBS_RUN: timer <= '0;
      endcase
    end
  end

  // Master drive during the 100ns pulse; all else released
  logic pulse_win;
  assign pulse_win = (timer < 23'(PULSE_CYC));
  always_comb begin
    switch_node_out = 6'h00;
    switch_node_oe  = 6'h00;
    if (state == DBS_PULSE1 && pulse_win) begin
      switch_node_out = DBS_CH1_MASTER;
      switch_node_oe  = DBS_CH1_MASTER;
    end else if (state == DBS_PULSE2 && pulse_win) begin
      switch_node_out = DBS_CH2_MASTER;
      switch_node_oe  = DBS_CH2_MASTER;
    end
  end

  assign block_pulldown_on = (state == DBS_PULSE1 || state == DBS_PULSE2) ? DBS_FLOATING : 6'h00;
  assign switching_allowed = bias_ok && blocks_ok && (state == DBS_RAMP || state == DBS_RUN);

  // ==========================================================================
  // Soft-start ramp
  // ==========================================================================
  // One step per interval; ramp speed is fixed, not scaled per channel
  localparam int STEP_CYC = SOFT_START / RAMP_STEPS;
  logic [22:0] step_cnt;
  logic [5:0]  ramp;
  logic        ramp_full;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      step_cnt  <= '0;
      ramp      <= RAMP_RST;
      ramp_full <= 1'b0;
    end else if (state != DBS_RAMP && state != DBS_RUN) begin
      step_cnt  <= '0;
      ramp      <= RAMP_RST;
      ramp_full <= 1'b0;
    end else if (!ramp_full) begin
      if (step_cnt == 23'(STEP_CYC - 1)) begin
        step_cnt <= '0;
        if (ramp == 6'h3f) begin
          ramp_full <= 1'b1;
        end else begin
          ramp <= ramp + 6'h01;
        end
      end else begin
        step_cnt <= step_cnt + 23'd1;
      end
    end
  end
  assign ramp_done = ramp_full;

  // Each channel ramps only while its own enable is high
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ch1_ref_code <= RAMP_RST;
      ch2_ref_code <= RAMP_RST;
    end else begin
      ch1_ref_code <= en1 ? ramp : RAMP_RST;
      ch2_ref_code <= en2 ? ramp : RAMP_RST;
    end
  end

  // ==========================================================================
  // Power good
  // ==========================================================================
  logic arm1;
  logic arm2;
  logic good1;
  logic good2;
  assign arm1 = (state == DBS_RUN) && sys_en && en1;
  assign arm2 = (state == DBS_RUN) && sys_en && en2;

  dbs_pg_window u_pg1 (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .armed     (arm1),
    .over_115  (sync_b[1]),
    .below_110 (fb_b[2]),
    .under_85  (sync_b[0]),
    .at_90     (fb_b[0]),
    .good      (good1)
  );

  dbs_pg_window u_pg2 (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .armed     (arm2),
    .over_115  (fb_b[5]),
    .below_110 (fb_b[3]),
    .under_85  (fb_b[4]),
    .at_90     (fb_b[1]),
    .good      (good2)
  );

  // Open drain: enable high pulls the pin low; the drop must not wait a cycle
  assign ch1_power_good    = 1'b0;
  assign ch2_power_good    = 1'b0;
  assign ch1_power_good_oe = !(good1 && arm1);
  assign ch2_power_good_oe = !(good2 && arm2);

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_pass_check;
    (state == DBS_PULSE2) ##1 (state == DBS_GAP);
  endsequence

  pass_wait_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !start_req)
    s_pass_check |-> (state == DBS_GAP) [*8])
    else $error("soft-start started before the settle gap");

  retry_path_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == DBS_RETRY && start_req) |=> (state inside {DBS_RETRY, DBS_PULSE1, DBS_IDLE}))
    else $error("failed check left the retry loop");

  fault_block_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == DBS_RETRY) |-> cfg_fault && !switching_allowed)
    else $error("switching allowed on bad configuration");

  pulldown_win_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (block_pulldown_on != 6'h00) |-> (state inside {DBS_PULSE1, DBS_PULSE2}))
    else $error("pull-downs active outside the check");

  supply_inhibit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !blocks_ok |-> !switching_allowed)
    else $error("switching with block supply low");

  pg_enable_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(sys_en && en1) |-> ch1_power_good_oe)
    else $error("channel one power good released while disabled");

  pg_ramp_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state != DBS_RUN) |-> ch1_power_good_oe && ch2_power_good_oe)
    else $error("power good released before soft-start end");

  skip_check_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == DBS_IDLE && checked_ok && start_req) |=> (state == DBS_RAMP))
    else $error("check repeated after a pass");

  pulse_len_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !start_req)
    $rose(switch_node_oe[1]) |-> switch_node_oe[1] [*4] ##1 !switch_node_oe[1])
    else $error("master pulse not 100ns");

endmodule // dbs_sequencer

//--- core/dbs_pkg.sv
// Constants and types shared by the dual buck start-up sequencer.
// Assumes a single 40 MHz system clock standing in for the internal oscillator.
//
// Overview of operation
// - Decode each channel's two select bits into a feedback scale code.
// - Select inputs default low when open, selecting the lowest setting.
// - Both select bits low means bare 0.6V reference, external divider.
// - All timing derives from one fixed-rate clock, nominally 40 MHz oscillator.
// - Bias rising threshold selection follows channel two voltage code.
// - Any block supply not good inhibits switching, switch nodes high impedance.
// - Check starts once supplies good, system enable and a channel enable high.
// - Each channel starts only when its own enable is high.
// - System-enable current sink on only while enable input is below threshold.
// - Latch block configuration when bias first good; resample after bias drop.
// - Pulse channel one master 100ns, sense sharing nodes, compare with config.
// - Then pulse channel two master, sense non-master nodes, compare.
// - Floating block pull-downs enabled only while the check runs.
// - After a passing check wait 100us, then start soft-start.
// - After a failing check repeat every 100us until valid or power lost.
// - After a pass skip checks until bias drops; re-enable goes to soft-start.
// - Soft-start steps reference from zero to full over 4ms.
// - Power-good low in shutdown and start; released after soft-start completes.
// - Power-good drops at once when channel or system enable is removed.
// - Above 115% power-good low until feedback falls below 110%.
// - Below 85% power-good low until feedback returns to 90% or above.
// - Block config code maps to current split and switch-node ownership.
// - Connectivity mismatch, such as tied masters, withholds soft-start on both.

package dbs_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int  CLK_HZ            = 40_000_000;
  localparam int  PULSE_NS          = 100;
  localparam int  PULSE_CYC         = (PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int  CHECK_GAP_US      = 100;
  localparam int  CHECK_GAP_CYC     = CHECK_GAP_US * (CLK_HZ / 1_000_000);
  localparam int  SOFT_START_MS     = 4;
  localparam int  SOFT_START_CYC    = SOFT_START_MS * (CLK_HZ / 1_000);
  localparam int  RAMP_STEPS        = 64;
  // Sensed nodes trail the pins by two sync flops, so the last pulse cycle
  // shows up one cycle after the pulse window closes
  localparam int  SETTLE_CYC        = 1;

  // ==========================================================================
  // Voltage codes: scale relative to 0.6V reference
  // ==========================================================================
  typedef enum logic [2:0] {
    DBS_SCALE_EXT  = 3'h0,
    DBS_SCALE_1V2  = 3'h1,
    DBS_SCALE_1V5  = 3'h2,
    DBS_SCALE_1V8  = 3'h3,
    DBS_SCALE_2V5  = 3'h4,
    DBS_SCALE_3V3  = 3'h5
  } dbs_scale_e;

  // Switch-node index bits 0..5 stand for nodes one to six; masters are 2 and 5
  localparam logic [5:0] DBS_CH1_MASTER = 6'h02;
  localparam logic [5:0] DBS_CH2_MASTER = 6'h10;
  localparam logic [5:0] DBS_FLOATING   = 6'h2d;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [1:0] CFG_RST      = 2'h0;
  localparam logic [5:0] RAMP_RST     = 6'h00;

endpackage

//--- core/dbs_pg_window.sv
// Per-channel power-good window with hysteresis.
// Assumes comparator results are already synchronised to clk_sys.
`timescale 1ns/1ps

module dbs_pg_window
  import dbs_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic armed,
  input  wire logic over_115,
  input  wire logic below_110,
  input  wire logic under_85,
  input  wire logic at_90,
  output logic      good
);

  logic ov_trip;
  logic uv_trip;

  // ==========================================================================
  // Window trackers
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ov_trip <= 1'b0;
    end else if (!armed) begin
      ov_trip <= 1'b0;
    end else if (over_115) begin
      ov_trip <= 1'b1;
    end else if (below_110) begin
      ov_trip <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      uv_trip <= 1'b0;
    end else if (!armed) begin
      uv_trip <= 1'b0;
    end else if (under_85) begin
      uv_trip <= 1'b1;
    end else if (at_90) begin
      uv_trip <= 1'b0;
    end
  end

  // Window only counts once the channel is armed after its ramp
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      good <= 1'b0;
    end else begin
      good <= armed && !ov_trip && !uv_trip && !over_115 && !under_85;
    end
  end

  ov_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (armed && over_115) |=> !good)
    else $error("power good not dropped on overvoltage");

  uv_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (uv_trip && armed && !at_90) |=> !good)
    else $error("power good released before 90 percent");

endmodule // dbs_pg_window

//--- verif/dbs_stage_model.sv
// Behavioural power stage: inductor wiring of the six switch nodes.
// Assumes the bench gives the node groups tied to each channel's inductor.
`timescale 1ns/1ps

module dbs_stage_model (
  input  wire logic [5:0] switch_node_out,
  input  wire logic [5:0] switch_node_oe,
  input  wire logic [5:0] ch1_group,
  input  wire logic [5:0] ch2_group,
  output logic      [5:0] switch_node_in
);
  // ==========================================================================
  // Node sensing
  // ==========================================================================
  // An undriven group sits at the discharged output through its inductor, so it reads low
  logic [5:0] drive_hi;
  assign drive_hi = switch_node_out & switch_node_oe;
  assign switch_node_in = ((|(drive_hi & ch1_group)) ? ch1_group : 6'h00)
                        | ((|(drive_hi & ch2_group)) ? ch2_group : 6'h00) | drive_hi;
endmodule // dbs_stage_model

//--- verif/tb_top.sv
// Self-checking bench for the dual buck start-up sequencer.
// Assumes shortened gap and soft-start counts; inputs change on the falling edge.
`timescale 1ns/1ps

module tb_top;
  import dbs_pkg::*;
  localparam int GAP = 20;
  localparam int SS  = 640;
  logic clk_sys = 0, sys_rst = 1, pulse_seen = 0;
  logic v1a = 0, v1b = 0, v2a = 0, v2b = 0, cfg_a = 1, cfg_b = 1, bias = 0, sysen = 0, en1 = 0, en2 = 0;
  logic [5:0] blocks = 6'h3f, g1 = 6'h3f, g2 = 6'h3f, sn_in, sn_out, sn_oe, pd, r1, r2;
  logic [1:0] ov = 2'h0, b110 = 2'h3, uv = 2'h0, a90 = 2'h3, split;
  logic [2:0] s1, s2;
  logic       bth, sink, sw_ok, fault, pg1, pg1_oe, pg2, pg2_oe;
  int         miscompares = 0, n_checks = 0, n;

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (sn_oe !== 6'h00) pulse_seen = 1'b1;

  dbs_stage_model stage (.switch_node_out(sn_out), .switch_node_oe(sn_oe), .ch1_group(g1), .ch2_group(g2),
                         .switch_node_in(sn_in));
  dbs_sequencer #(.CHECK_GAP(GAP), .SOFT_START(SS)) DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ch1_vsel_first(v1a), .ch1_vsel_second(v1b),
    .ch2_vsel_first(v2a), .ch2_vsel_second(v2b), .block_cfg_sel_first(cfg_a), .block_cfg_sel_second(cfg_b),
    .bias_good_in(bias), .block_supply_in(blocks), .sys_enable_in(sysen), .ch1_enable_in(en1),
    .ch2_enable_in(en2), .switch_node_in(sn_in), .fb_over_115(ov), .fb_below_110(b110), .fb_under_85(uv),
    .fb_at_90(a90), .ch1_scale(s1), .ch2_scale(s2), .bias_thresh_high(bth), .sys_enable_sink_on(sink),
    .switch_node_out(sn_out), .switch_node_oe(sn_oe), .block_pulldown_on(pd), .switching_allowed(sw_ok),
    .cfg_split(split), .cfg_fault(fault), .ch1_ref_code(r1), .ch2_ref_code(r2), .ch1_power_good(pg1),
    .ch1_power_good_oe(pg1_oe), .ch2_power_good(pg2), .ch2_power_good_oe(pg2_oe));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  function automatic logic cond(input int sel);
    case (sel)
      0: return sn_oe[1];
      1: return sn_oe[4];
      2: return r1 != 6'h00;
      3: return !pg1_oe;
      4: return pg1_oe;
      default: return fault;
    endcase
  endfunction

  // Bounded wait; running out is a mismatch and ends the run
  task automatic wait_on(input int sel, input int lim, output int cnt);
    cnt = 0;
    while (cond(sel) !== 1'b1 && cnt < lim) begin
      @(negedge clk_sys);
      cnt++;
    end
    if (cnt >= lim) begin
      miscompares++;
      $display("wrong value at %0t: wait %0h gave up after %0h", $time, sel, lim);
      print_verdict();
    end
  endtask

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    static logic [2:0] exp1 [4] = '{3'h0, 3'h2, 3'h1, 3'h3};
    static logic [2:0] exp2 [4] = '{3'h0, 3'h4, 3'h3, 3'h5};
    repeat (16) @(negedge clk_sys);
    sys_rst = 0;
    for (int i = 0; i < 4; i++) begin
      {v1a, v1b} = i[1:0];
      {v2a, v2b} = i[1:0];
      repeat (4) @(negedge clk_sys);
      check(s1, exp1[i]);
      check(s2, exp2[i]);
      check(bth, i == 3);
    end
    check(sink, 1);
    // Tied masters: check must fail, retry and hold the ramp off
    bias = 1;
    sysen = 1;
    en1 = 1;
    wait_on(0, 8, n);
    check(pd, 6'h2d);
    check(sink, 0);
    wait_on(5, 40, n);
    repeat (2) @(negedge clk_sys);
    wait_on(0, GAP + 40, n);
    check(r1, 6'h00);
    // Power removal re-latches; correct wiring for code 11
    bias = 0;
    repeat (6) @(negedge clk_sys);
    g1 = 6'h07;
    g2 = 6'h38;
    bias = 1;
    wait_on(1, 40, n);
    wait_on(2, GAP + 60, n);
    check(n >= GAP, 1);
    check(fault, 0);
    // Straps move after the latch; the held code must not follow them
    cfg_a = 0;
    cfg_b = 0;
    wait_on(3, SS + 100, n);
    check(n >= SS - 40, 1);
    check(r1, 6'h3f);
    check(r2, 6'h00);
    check(pg2_oe, 1);
    check(pg1, 0);
    check(pg2, 0);
    check(sw_ok, 1);
    check(split, 2'h3);
    // Over-voltage trip holds until below the recovery level
    ov = 2'h1;
    b110 = 2'h2;
    wait_on(4, 8, n);
    ov = 2'h0;
    repeat (6) @(negedge clk_sys);
    check(pg1_oe, 1);
    b110 = 2'h3;
    wait_on(3, 8, n);
    uv = 2'h1;
    a90 = 2'h2;
    wait_on(4, 8, n);
    uv = 2'h0;
    repeat (6) @(negedge clk_sys);
    check(pg1_oe, 1);
    a90 = 2'h3;
    wait_on(3, 8, n);
    en1 = 0;
    wait_on(4, 5, n);
    repeat (4) @(negedge clk_sys);
    pulse_seen = 0;
    en1 = 1;
    wait_on(2, 40, n);
    check(pulse_seen, 0);
    blocks = 6'h3e;
    repeat (5) @(negedge clk_sys);
    check(sw_ok, 0);
    check(sn_oe, 6'h00);
    // Bias loss re-latches code 00; both channels share one ramp
    bias = 0;
    repeat (6) @(negedge clk_sys);
    g1 = 6'h03;
    g2 = 6'h3c;
    blocks = 6'h3f;
    en2 = 1;
    bias = 1;
    wait_on(3, SS + GAP + 120, n);
    check(split, 2'h0);
    check(fault, 0);
    check(r2, 6'h3f);
    check(pg2_oe, 0);
    // Channel two trips alone; channel one keeps its window
    ov = 2'h2;
    b110 = 2'h1;
    repeat (4) @(negedge clk_sys);
    check(pg2_oe, 1);
    check(pg1_oe, 0);
    print_verdict();
  end
endmodule // tb_top
